// ---- lcc_config_regs.sv ----
// Operation
// RQ1 - the lane registers are read and written by the management host.
// RQ2 - the equalizer field has an enable bit, a gain stage and a boost.
// RQ3 - the equalizer field resets to bypass, code 20 hex.
// RQ4 - known equalizer codes 2A..3D hex map to rising boost ranks.
// RQ5 - primary swing is bits 6:0, 03 hex default low, 07 hex high.
// RQ6 - each output lane has an eight-bit secondary swing register.
// RQ7 - idle threshold holds de-assert in bits 3:2 and assert in 1:0.
// RQ8 - threshold codes rise with value, 00 default lowest pair.
// RQ9 - idle-auto set means automatic idle detection drives muting.
// RQ10 - without auto, select 0 keeps output on, 1 mutes it.
// RQ11 - a global two-bit swing trim, 10 default meaning no change.
// RQ12 - the host writes zero to reserved bits and relies on none.
`timescale 1ns/1ps
module lcc_config_regs (
  input  wire logic                       sys_clk_i,
  input  wire logic                       reset_i,
  input  wire logic [lcc_pkg::LCC_AW-1:0] reg_addr_i,
  input  wire logic [lcc_pkg::LCC_DW-1:0] reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  input  wire logic                       idle_detect_i,
  output logic      [lcc_pkg::LCC_DW-1:0] reg_rdata_o,
  output logic                            reg_rvalid_o,
  output logic                            reg_hit_o,
  output logic                            eq_enable_o,
  output logic      [1:0]                 eq_gain_stage_o,
  output logic      [2:0]                 eq_boost_o,
  output logic      [3:0]                 eq_rank_o,
  output logic      [6:0]                 a_swing_primary_o,
  output logic      [7:0]                 a_swing_secondary_o,
  output logic      [6:0]                 b_swing_primary_o,
  output logic      [7:0]                 b_swing_secondary_o,
  output logic                            b_mute_o,
  output logic                            b_signal_detect_en_o,
  output logic      [1:0]                 idle_deassert_thr_o,
  output logic      [1:0]                 idle_assert_thr_o,
  output lcc_pkg::lcc_trim_t              swing_trim_o
);
  import lcc_pkg::*;

  // ==========================================================
  // address decode
  function automatic logic [3:0] lcc_decode(input logic [7:0] addr);
    logic [3:0] res;
    res = 4'h0;
    for (int i = 0; i < LCC_NUM_REGS; i++) begin
      if (addr == LCC_OFFSET[i]) begin
        res = {1'b1, i[2:0]};
      end
    end
    return res;
  endfunction

  function automatic logic [3:0] lcc_eq_rank(input logic [5:0] code);
    logic [3:0] rank;
    rank = LCC_EQ_RANK_NONE;
    for (int i = 0; i < LCC_EQ_NUM_CODES; i++) begin
      if (code == LCC_EQ_CODES[i]) begin
        rank = i[3:0];
      end
    end
    return rank;
  endfunction

  logic [3:0] wr_dec;
  logic [3:0] rd_dec;
  logic [7:0] regs [LCC_NUM_REGS];
  logic [LCC_NUM_REGS-1:0] wr_sel;

  assign wr_dec = lcc_decode(reg_addr_i);
  assign rd_dec = lcc_decode(reg_addr_i);

  // ==========================================================
  // register storage
  for (genvar g = 0; g < LCC_NUM_REGS; g++) begin : g_reg
    assign wr_sel[g] = reg_wr_i && wr_dec[3] &&
                       (wr_dec[2:0] == 3'(g)); // [RQ1]
    lcc_reg_cell #(
      .RESET_VAL (LCC_RESET[g]), // [RQ3]
      .MASK      (LCC_MASK[g])   // [RQ12]
    ) u_cell (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .wr_en_i   (wr_sel[g]),
      .wdata_i   (reg_wdata_i),
      .q_o       (regs[g])
    );
  end

  // ==========================================================
  // read port
  logic [7:0] next_rdata;
  logic       next_rvalid;
  logic       next_hit;

  // unmapped reads answer zero
  always_comb begin
    next_rdata  = 8'h00;
    next_rvalid = reg_rd_i;
    next_hit    = reg_hit_o;
    if (reg_rd_i) begin
      next_hit = rd_dec[3];
      if (rd_dec[3]) begin
        next_rdata = regs[rd_dec[2:0]]; // [RQ1]
      end
    end else if (reg_wr_i) begin
      next_hit = wr_dec[3];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
      reg_hit_o    <= 1'b0;
    end else begin
      reg_rdata_o  <= next_rdata;
      reg_rvalid_o <= next_rvalid;
      reg_hit_o    <= next_hit;
    end
  end

  // ==========================================================
  // idle detector synchroniser
  logic idle_meta;
  logic idle_sync;
  logic next_idle_meta;
  logic next_idle_sync;

  // only the second stage reads the first
  always_comb begin
    next_idle_meta = idle_detect_i;
    next_idle_sync = idle_meta;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      idle_meta <= 1'b0;
      idle_sync <= 1'b0;
    end else begin
      idle_meta <= next_idle_meta;
      idle_sync <= next_idle_sync;
    end
  end

  // ==========================================================
  // decoded conditioning settings
  logic       next_eq_en;
  logic [1:0] next_gain;
  logic [2:0] next_boost;
  logic [3:0] next_rank;
  logic [6:0] next_a_sw1;
  logic [7:0] next_a_sw2;
  logic [6:0] next_b_sw1;
  logic [7:0] next_b_sw2;
  logic       next_mute;
  logic       next_signal_detect_en;
  logic [1:0] next_deassert;
  logic [1:0] next_assert;
  lcc_trim_t  next_trim;
  logic [7:0] eq_reg;
  logic [7:0] idle_reg;
  logic [7:0] thr_reg;

  always_comb begin
    eq_reg        = regs[LCC_IDX_EQ];
    idle_reg      = regs[LCC_IDX_B_IDLE];
    thr_reg       = regs[LCC_IDX_IDLE_THR];
    next_eq_en    = eq_reg[LCC_EQ_EN_BIT];                     // [RQ2]
    next_gain     = eq_reg[LCC_EQ_GAIN_LSB +: 2];              // [RQ2]
    next_boost    = eq_reg[LCC_EQ_BOOST_LSB +: 3];             // [RQ2]
    next_rank     = lcc_eq_rank(eq_reg[5:0]);                  // [RQ4]
    next_a_sw1    = regs[LCC_IDX_A_SW1][6:0];                  // [RQ5]
    next_a_sw2    = regs[LCC_IDX_A_SW2];                       // [RQ6]
    next_b_sw1    = regs[LCC_IDX_B_SW1][6:0];                  // [RQ5]
    next_b_sw2    = regs[LCC_IDX_B_SW2];                       // [RQ6]
    next_deassert = thr_reg[LCC_THR_DEASRT_LSB +: 2];          // [RQ7]
    next_assert   = thr_reg[LCC_THR_ASRT_LSB +: 2];            // [RQ8]
    next_trim     = lcc_trim_t'(regs[LCC_IDX_TRIM][1:0]);      // [RQ11]
    if (idle_reg[LCC_IDLE_AUTO_BIT]) begin
      next_mute             = idle_sync;                     // [RQ9]
      next_signal_detect_en = 1'b1;
    end else begin
      next_mute             = idle_reg[LCC_IDLE_SEL_BIT];    // [RQ10]
      next_signal_detect_en = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      eq_enable_o          <= LCC_RESET[LCC_IDX_EQ][LCC_EQ_EN_BIT];
      eq_gain_stage_o      <= LCC_RESET[LCC_IDX_EQ][LCC_EQ_GAIN_LSB +: 2];
      eq_boost_o           <= LCC_RESET[LCC_IDX_EQ][LCC_EQ_BOOST_LSB +: 3];
      eq_rank_o            <= 4'h0;
      a_swing_primary_o    <= LCC_RESET[LCC_IDX_A_SW1][6:0];
      a_swing_secondary_o  <= LCC_RESET[LCC_IDX_A_SW2];
      b_swing_primary_o    <= LCC_RESET[LCC_IDX_B_SW1][6:0];
      b_swing_secondary_o  <= LCC_RESET[LCC_IDX_B_SW2];
      b_mute_o             <= 1'b0;
      b_signal_detect_en_o <= 1'b0;
      idle_deassert_thr_o  <= 2'h0;
      idle_assert_thr_o    <= 2'h0;
      swing_trim_o         <= LCC_TRIM_NOMINAL;
    end else begin
      eq_enable_o          <= next_eq_en;
      eq_gain_stage_o      <= next_gain;
      eq_boost_o           <= next_boost;
      eq_rank_o            <= next_rank;
      a_swing_primary_o    <= next_a_sw1;
      a_swing_secondary_o  <= next_a_sw2;
      b_swing_primary_o    <= next_b_sw1;
      b_swing_secondary_o  <= next_b_sw2;
      b_mute_o             <= next_mute;
      b_signal_detect_en_o <= next_signal_detect_en;
      idle_deassert_thr_o  <= next_deassert;
      idle_assert_thr_o    <= next_assert;
      swing_trim_o         <= next_trim;
    end
  end

endmodule

// ---- lcc_pkg.sv ----
package lcc_pkg;

  // ==========================================================
  // register map
  localparam int       LCC_NUM_REGS = 8;
  localparam int       LCC_AW       = 8;
  localparam int       LCC_DW       = 8;

  localparam int       LCC_IDX_EQ       = 0;
  localparam int       LCC_IDX_A_SW1    = 1;
  localparam int       LCC_IDX_A_SW2    = 2;
  localparam int       LCC_IDX_IDLE_THR = 3;
  localparam int       LCC_IDX_B_IDLE   = 4;
  localparam int       LCC_IDX_B_SW1    = 5;
  localparam int       LCC_IDX_B_SW2    = 6;
  localparam int       LCC_IDX_TRIM     = 7;

  localparam logic [7:0] LCC_OFFSET [LCC_NUM_REGS] = '{
    8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h40, 8'h42, 8'h43, 8'h47
  };
  localparam logic [7:0] LCC_RESET [LCC_NUM_REGS] = '{
    8'h20, 8'h03, 8'h03, 8'h00, 8'h00, 8'h03, 8'h03, 8'h02
  };
  // implemented bits; reserved bits are not stored and read zero
  localparam logic [7:0] LCC_MASK [LCC_NUM_REGS] = '{
    8'h3F, 8'h7F, 8'hFF, 8'h0F, 8'h30, 8'h7F, 8'hFF, 8'h03
  };

  // ==========================================================
  // field positions
  localparam int       LCC_EQ_EN_BIT      = 5;
  localparam int       LCC_EQ_GAIN_LSB    = 3;
  localparam int       LCC_EQ_BOOST_LSB   = 0;
  localparam int       LCC_IDLE_AUTO_BIT  = 5;
  localparam int       LCC_IDLE_SEL_BIT   = 4;
  localparam int       LCC_THR_DEASRT_LSB = 2;
  localparam int       LCC_THR_ASRT_LSB   = 0;

  // ==========================================================
  // equalizer code table, lowest to highest boost
  localparam int       LCC_EQ_NUM_CODES = 8;
  localparam logic [5:0] LCC_EQ_CODES [LCC_EQ_NUM_CODES] = '{
    6'h20, 6'h2A, 6'h30, 6'h32, 6'h35, 6'h37, 6'h3B, 6'h3D
  };
  localparam logic [3:0] LCC_EQ_RANK_NONE = 4'hF;

  // ==========================================================
  // swing trim codes
  typedef enum logic [1:0] {
    LCC_TRIM_MINUS_25   = 2'h0,
    LCC_TRIM_MINUS_12P5 = 2'h1,
    LCC_TRIM_NOMINAL    = 2'h2,
    LCC_TRIM_PLUS_12P5  = 2'h3
  } lcc_trim_t;

endpackage

// ---- lcc_reg_cell.sv ----
`timescale 1ns/1ps
module lcc_reg_cell #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] MASK      = 8'hFF
) (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] q_o
);

  logic [7:0] next_q;

  // ==========================================================
  // storage
  always_comb begin
    next_q = q_o;
    if (wr_en_i) begin
      next_q = wdata_i & MASK;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      q_o <= RESET_VAL & MASK;
    end else begin
      q_o <= next_q;
    end
  end

endmodule

// ---- lcc_host_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// management host driving the register strobes
module lcc_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o
);
  initial begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end
  // reserved bits are sent as the caller gives them; the tests pass them as zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(posedge sys_clk_i);
    #1;
    reg_wr_o    = 1'b0;
    reg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge sys_clk_i);
    #1;
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(posedge sys_clk_i);
    #1;
    reg_rd_o = 1'b0;
    for (n = 0; n < 4 && reg_rvalid_i !== 1'b1; n++) @(posedge sys_clk_i);
    d = reg_rdata_i;
    if (n == 4) begin
      tb_top.n_errors++;
      tb_top.complete_run();
    end
  endtask
endmodule

// ---- lcc_checker_assertions.sv ----
`timescale 1ns/1ps
// ==========================================================
// register bank checks
module lcc_checker (
  input wire logic               sys_clk_i,
  input wire logic               reset_i,
  input wire logic [7:0]         reg_addr_i,
  input wire logic [7:0]         reg_wdata_i,
  input wire logic               reg_wr_i,
  input wire logic               reg_rd_i,
  input wire logic               idle_detect_i,
  input wire logic [7:0]         reg_rdata_o,
  input wire logic               reg_rvalid_o,
  input wire logic               eq_enable_o,
  input wire logic [1:0]         eq_gain_stage_o,
  input wire logic [2:0]         eq_boost_o,
  input wire logic [3:0]         eq_rank_o,
  input wire logic [6:0]         a_swing_primary_o,
  input wire logic               b_mute_o,
  input wire logic               b_signal_detect_en_o,
  input wire logic [1:0]         idle_deassert_thr_o,
  input wire logic [1:0]         idle_assert_thr_o,
  input wire lcc_pkg::lcc_trim_t swing_trim_o
);
  import lcc_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_wr(a);
    reg_wr_i && reg_addr_i == a ##1 !(reg_wr_i && reg_addr_i == a);
  endsequence
  property p_wr(a, q, m);
    s_wr(a) |=> q == ($past(reg_wdata_i, 2) & m);
  endproperty
  sequence s_wr_manual;
    reg_wr_i && reg_addr_i == 8'h40 && !reg_wdata_i[LCC_IDLE_AUTO_BIT]
      ##1 !(reg_wr_i && reg_addr_i == 8'h40);
  endsequence
  a_rd_answer_next: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered next cycle");
  a_rdata_idle_zero: assert property (
    !reg_rvalid_o |-> reg_rdata_o == 8'h00)
    else $error("read data not zero when idle");
  a_eq_fields_follow: assert property (p_wr(8'h3A,
    {eq_enable_o, eq_gain_stage_o, eq_boost_o}, 8'h3F))
    else $error("equalizer fields wrong");
  a_eq_rank_top: assert property ({eq_enable_o, eq_gain_stage_o,
    eq_boost_o} == 6'h3D |-> eq_rank_o == 4'h7)
    else $error("top boost rank wrong");
  a_swing_a_follow: assert property (
    p_wr(8'h3B, a_swing_primary_o, 8'h7F))
    else $error("primary swing wrong");
  a_thr_fields_follow: assert property (p_wr(8'h3D,
    {idle_deassert_thr_o, idle_assert_thr_o}, 8'h0F))
    else $error("threshold fields wrong");
  a_trim_code_follow: assert property (p_wr(8'h47, swing_trim_o, 8'h03))
    else $error("swing trim wrong");
  a_auto_mute_sync: assert property (b_signal_detect_en_o &&
    $past(b_signal_detect_en_o, 3) |-> b_mute_o == $past(idle_detect_i, 3))
    else $error("auto mute not following detector");
  a_manual_mute_sel: assert property (s_wr_manual |=>
    !b_signal_detect_en_o && b_mute_o == $past(reg_wdata_i[4], 2))
    else $error("manual mute not following select bit");
endmodule
bind lcc_config_regs lcc_checker u_chk (
  .sys_clk_i            (sys_clk_i),
  .reset_i              (reset_i),
  .reg_addr_i           (reg_addr_i),
  .reg_wdata_i          (reg_wdata_i),
  .reg_wr_i             (reg_wr_i),
  .reg_rd_i             (reg_rd_i),
  .idle_detect_i        (idle_detect_i),
  .reg_rdata_o          (reg_rdata_o),
  .reg_rvalid_o         (reg_rvalid_o),
  .eq_enable_o          (eq_enable_o),
  .eq_gain_stage_o      (eq_gain_stage_o),
  .eq_boost_o           (eq_boost_o),
  .eq_rank_o            (eq_rank_o),
  .a_swing_primary_o    (a_swing_primary_o),
  .b_mute_o             (b_mute_o),
  .b_signal_detect_en_o (b_signal_detect_en_o),
  .idle_deassert_thr_o  (idle_deassert_thr_o),
  .idle_assert_thr_o    (idle_assert_thr_o),
  .swing_trim_o         (swing_trim_o)
);

// ---- tb_top.sv ----
`timescale 1ns/1ps
// ==========================================================
// register bank testbench
module tb_top;
  import lcc_pkg::*;
  logic       sys_clk_i     = 1'b0;
  logic       reset_i       = 1'b1;
  logic       idle_detect_i = 1'b0;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [7:0] a_swing_secondary_o, b_swing_secondary_o;
  logic       reg_wr_i, reg_rd_i, reg_rvalid_o, reg_hit_o, eq_enable_o;
  logic       b_mute_o, b_signal_detect_en_o;
  logic [1:0] eq_gain_stage_o, idle_deassert_thr_o, idle_assert_thr_o;
  logic [2:0] eq_boost_o;
  logic [3:0] eq_rank_o;
  logic [6:0] a_swing_primary_o, b_swing_primary_o;
  lcc_trim_t  swing_trim_o;
  int         n_errors    = 0;
  int         comparisons = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  lcc_config_regs dut (
    .sys_clk_i            (sys_clk_i),
    .reset_i              (reset_i),
    .reg_addr_i           (reg_addr_i),
    .reg_wdata_i          (reg_wdata_i),
    .reg_wr_i             (reg_wr_i),
    .reg_rd_i             (reg_rd_i),
    .idle_detect_i        (idle_detect_i),
    .reg_rdata_o          (reg_rdata_o),
    .reg_rvalid_o         (reg_rvalid_o),
    .reg_hit_o            (reg_hit_o),
    .eq_enable_o          (eq_enable_o),
    .eq_gain_stage_o      (eq_gain_stage_o),
    .eq_boost_o           (eq_boost_o),
    .eq_rank_o            (eq_rank_o),
    .a_swing_primary_o    (a_swing_primary_o),
    .a_swing_secondary_o  (a_swing_secondary_o),
    .b_swing_primary_o    (b_swing_primary_o),
    .b_swing_secondary_o  (b_swing_secondary_o),
    .b_mute_o             (b_mute_o),
    .b_signal_detect_en_o (b_signal_detect_en_o),
    .idle_deassert_thr_o  (idle_deassert_thr_o),
    .idle_assert_thr_o    (idle_assert_thr_o),
    .swing_trim_o         (swing_trim_o)
  );
  lcc_host_model host (.sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr_settle(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic t_reset();
    logic [7:0] d;
    chk({7'h00, eq_enable_o}, 8'h01);
    chk({6'h00, idle_assert_thr_o}, 8'h00);
    chk({6'h00, swing_trim_o}, 8'h02);
    for (int i = 0; i < LCC_NUM_REGS; i++) begin
      host.rd(LCC_OFFSET[i], d);
      chk(d, LCC_RESET[i]);
    end
  endtask
  task automatic t_rw();
    logic [7:0] d;
    logic [7:0] p;
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < LCC_NUM_REGS; i++) begin
        p = (k == 0 ? 8'hAA : 8'h55) & LCC_MASK[i];
        host.wr(LCC_OFFSET[i], p);
        host.rd(LCC_OFFSET[i], d);
        chk(d, p);
      end
    end
    host.rd(8'h3E, d);
    chk(d, 8'h00);
    chk({7'h00, reg_hit_o}, 8'h00);
    wr_settle(8'h3B, 8'h07);
    chk({1'b0, a_swing_primary_o}, 8'h07);
    wr_settle(8'h43, 8'h01);
    chk(b_swing_secondary_o, 8'h01);
    wr_settle(8'h3C, 8'h01);
    chk(a_swing_secondary_o, 8'h01);
    wr_settle(8'h42, 8'h07);
    chk({1'b0, b_swing_primary_o}, 8'h07);
    chk({7'h00, reg_hit_o}, 8'h01);
  endtask
  task automatic t_equalizer();
    for (int i = 0; i < LCC_EQ_NUM_CODES; i++) begin
      wr_settle(8'h3A, {2'h0, LCC_EQ_CODES[i]});
      chk({4'h0, eq_rank_o}, 8'(i));
      chk({2'h0, eq_enable_o, eq_gain_stage_o, eq_boost_o},
          {2'h0, LCC_EQ_CODES[i]});
    end
    wr_settle(8'h3A, 8'h15);
    chk({4'h0, eq_rank_o}, {4'h0, LCC_EQ_RANK_NONE});
  endtask
  task automatic t_idle();
    idle_detect_i = 1'b1;
    wr_settle(8'h40, 8'h10);
    chk({b_mute_o, b_signal_detect_en_o}, 8'h02);
    wr_settle(8'h40, 8'h00);
    chk({b_mute_o, b_signal_detect_en_o}, 8'h00);
    wr_settle(8'h40, 8'h20);
    chk({b_mute_o, b_signal_detect_en_o}, 8'h03);
    idle_detect_i = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk({7'h00, b_mute_o}, 8'h00);
  endtask
  task automatic t_trim_thr();
    for (int c = 0; c < 4; c++) begin
      wr_settle(8'h47, 8'(c));
      chk({6'h00, swing_trim_o}, 8'(c));
    end
    wr_settle(8'h3D, 8'h0E);
    chk({4'h0, idle_deassert_thr_o, idle_assert_thr_o}, 8'h0E);
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_i);
    #1;
    reset_i = 1'b0;
    t_reset();
    t_rw();
    t_equalizer();
    t_idle();
    t_trim_thr();
    complete_run();
  end
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
endmodule
